// file: hw/chip_config_cfg.svh
`ifndef CHIP_CONFIG_CFG_SVH
`define CHIP_CONFIG_CFG_SVH
// Contract
// - Configuration bit 15 selects pad drive: 0 partial, 1 full; write-once.
// - Bits 10..8 read-only mode: 110 single-chip, 111 master; others reserved.
// - Bit 6 read/write enables the transfer-size pin function.
// - Bit 5 read/write enables processor status and debug data pin functions.
// - Bit 3 enables bus watchdog for external cycles; write-once.
// - Bits 2..0 pick watchdog timeout 65536 halving to 512 clocks; write-once.
// - Drive bit and mode field reset from the reset configuration outcome.
// - Transfer-size enable resets set in master mode, clear otherwise.
// - Watchdog enable resets set; every other unspecified bit resets clear.
// - Drive bit, watchdog enable and timeout follow the write-once scheme.
// - Reset default register is read-only and defines reset defaults.
// - Defaults are overridden only during reset with the override pin asserted.
// - Write-once bits always readable; later writes ignored outside debug.
// - Debug writes always allowed and leave the bit writable afterwards.
// - User mode accesses have no effect and end with a transfer error.
// - With override pin asserted, data pins sampled in reset set options.

// Word offsets from the peripheral base
`define CC_OFS_CCR 32'h0011_0004
`define CC_OFS_RESET_DEFAULT_CONFIG 32'h0011_0008
`define CC_OFS_RSVD 32'h0011_000c

// Configuration register field positions
`define CC_BIT_LOAD 15
`define CC_BIT_MODE_HI 10
`define CC_BIT_MODE_LO 8
`define CC_BIT_XFER_SIZE_PIN_ENABLE 6
`define CC_BIT_PROC_TRACE_PIN_ENABLE 5
`define CC_BIT_BME 3
`define CC_BIT_BMT_HI 2
`define CC_BIT_BMT_LO 0
`define CC_MODE_SINGLE 3'h6
`define CC_MODE_MASTER 3'h7
`define CC_BME_RESET 1'h1
`define CC_BMT_RESET 3'h0
`define CC_PROC_TRACE_PIN_ENABLE_RESET 1'h0

// Watchdog period for code 000, halved per increment
`define CC_WDOG_BASE_CYC 17'h10000

// Reset default register layout and value
`define CC_RESET_DEFAULT_CONFIG_RESET 16'h00e0
`define CC_RESET_DEFAULT_CONFIG_RCSC_HI 9
`define CC_RESET_DEFAULT_CONFIG_RCSC_LO 8
`define CC_RESET_DEFAULT_CONFIG_PLLSEL 7
`define CC_RESET_DEFAULT_CONFIG_PLLREF 6
`define CC_RESET_DEFAULT_CONFIG_LOAD 5
`define CC_RESET_DEFAULT_CONFIG_BOOTPS_HI 4
`define CC_RESET_DEFAULT_CONFIG_BOOTPS_LO 3
`define CC_RESET_DEFAULT_CONFIG_BOOTSEL 2
`define CC_RESET_DEFAULT_CONFIG_MODE 0

// Override data pin vector index (D26,D25,D24,D21,D19..D16 = 7..0)
`define CC_OVR_MODE 7
`define CC_OVR_LOAD 6
`define CC_OVR_BOOTSEL 5
`define CC_OVR_BOOTPS_HI 4
`define CC_OVR_BOOTPS_LO 3
`define CC_OVR_RCSC_HI 2
`define CC_OVR_RCSC_LO 1
`define CC_OVR_PLLSEL 0
`define CC_OVR_WIDTH 8

`endif

// file: hw/chip_config_pkg.sv
package chip_config_pkg;

  typedef struct packed {
    logic [1:0] rcsc;
    logic pllsel;
    logic pllref;
    logic load;
    logic [1:0] bootps;
    logic bootsel;
    logic master;
  } rcfg_s;

  typedef struct packed {
    logic req;
    logic write;
    logic supervisor;
    logic [31:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } bus_req_s;

  typedef struct packed {
    logic ack;
    logic terr;
    logic [31:0] rdata;
  } bus_rsp_s;

  typedef struct packed {
    logic full_drive;
    logic [2:0] chip_mode;
    logic xfer_size_pin_enable;
    logic proc_trace_pin_enable;
    logic bus_watchdog_enable;
    logic [2:0] bus_watchdog_timeout;
    logic [16:0] bus_watchdog_cycles;
  } ccr_out_s;

  typedef enum logic [1:0] {
    REG_CCR = 2'b00,
    REG_RESET_DEFAULT_CONFIG = 2'b01,
    REG_RSVD = 2'b10,
    REG_NONE = 2'b11
  } region_e;

endpackage

// file: hw/rcfg_capture.sv
`timescale 1ns/10ps
`include "chip_config_cfg.svh"

module rcfg_capture #(
  parameter logic [15:0] RESET_DEFAULT_CONFIG_DEFAULT = `CC_RESET_DEFAULT_CONFIG_RESET
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic rcfg_n,
  input wire logic [`CC_OVR_WIDTH-1:0] ovr_pins,
  input wire logic [1:0] clkmod_pins,
  output chip_config_pkg::rcfg_s live_cfg,
  output chip_config_pkg::rcfg_s held_cfg,
  output logic [1:0] held_clkmod,
  output logic held_override
);

  localparam int W = `CC_OVR_WIDTH + 3;

  logic [W-1:0] raw;
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] filt_r;
  logic ovr_on;
  logic [`CC_OVR_WIDTH-1:0] ovr;

  assign raw = {rcfg_n, clkmod_pins, ovr_pins};

  // Pins are free-running and must keep sampling while reset is held,
  // so the chain itself has no reset.
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_sync
      always_ff @(posedge clock) begin
        s1_r[i] <= raw[i];
        s2_r[i] <= s1_r[i];
        s3_r[i] <= s2_r[i];
        if (s2_r[i] == s3_r[i]) begin
          filt_r[i] <= s3_r[i];
        end
      end
    end
  endgenerate

  assign ovr_on = ~filt_r[W-1];
  assign ovr = filt_r[`CC_OVR_WIDTH-1:0];

  always_comb begin
    if (ovr_on) begin
      live_cfg.rcsc = ovr[`CC_OVR_RCSC_HI:`CC_OVR_RCSC_LO];
      live_cfg.pllsel = ovr[`CC_OVR_PLLSEL];
      live_cfg.pllref = RESET_DEFAULT_CONFIG_DEFAULT[`CC_RESET_DEFAULT_CONFIG_PLLREF];
      live_cfg.load = ovr[`CC_OVR_LOAD];
      live_cfg.bootps = ovr[`CC_OVR_BOOTPS_HI:`CC_OVR_BOOTPS_LO];
      live_cfg.bootsel = ovr[`CC_OVR_BOOTSEL];
      live_cfg.master = ovr[`CC_OVR_MODE];
    end else begin
      live_cfg.rcsc = RESET_DEFAULT_CONFIG_DEFAULT[`CC_RESET_DEFAULT_CONFIG_RCSC_HI:`CC_RESET_DEFAULT_CONFIG_RCSC_LO];
      live_cfg.pllsel = RESET_DEFAULT_CONFIG_DEFAULT[`CC_RESET_DEFAULT_CONFIG_PLLSEL];
      live_cfg.pllref = RESET_DEFAULT_CONFIG_DEFAULT[`CC_RESET_DEFAULT_CONFIG_PLLREF];
      live_cfg.load = RESET_DEFAULT_CONFIG_DEFAULT[`CC_RESET_DEFAULT_CONFIG_LOAD];
      live_cfg.bootps = RESET_DEFAULT_CONFIG_DEFAULT[`CC_RESET_DEFAULT_CONFIG_BOOTPS_HI:`CC_RESET_DEFAULT_CONFIG_BOOTPS_LO];
      live_cfg.bootsel = RESET_DEFAULT_CONFIG_DEFAULT[`CC_RESET_DEFAULT_CONFIG_BOOTSEL];
      live_cfg.master = RESET_DEFAULT_CONFIG_DEFAULT[`CC_RESET_DEFAULT_CONFIG_MODE];
    end
  end

  // Outcome follows the pins only while reset is held, then freezes
  always_ff @(posedge clock) begin
    if (srst) begin
      held_cfg <= live_cfg;
      held_clkmod <= filt_r[W-2:W-3];
      held_override <= ovr_on;
    end
  end

endmodule

// file: hw/chip_config_register.sv
`timescale 1ns/10ps
`include "chip_config_cfg.svh"

module chip_config_register #(
  parameter logic [15:0] RESET_DEFAULT_CONFIG_DEFAULT = `CC_RESET_DEFAULT_CONFIG_RESET
) (
  input wire logic CLOCK,
  input wire logic SRST,
  input chip_config_pkg::bus_req_s BUS_REQ,
  input wire logic DEBUG_MODE,
  input wire logic RCFG_N,
  input wire logic [`CC_OVR_WIDTH-1:0] RCFG_DATA,
  input wire logic [1:0] CLKMOD,
  output chip_config_pkg::bus_rsp_s BUS_RSP,
  output chip_config_pkg::ccr_out_s CCR_OUT,
  output chip_config_pkg::rcfg_s BOOT_CFG,
  output logic [1:0] CLOCK_MODE,
  output logic OVERRIDE_ACTIVE
);

  localparam int NWO = 3;
  localparam int WO_LOAD = 0;
  localparam int WO_BME = 1;
  localparam int WO_BMT = 2;

  chip_config_pkg::rcfg_s live_cfg;
  chip_config_pkg::rcfg_s held_cfg;
  chip_config_pkg::region_e region;

  logic load_r;
  logic [2:0] mode_r;
  logic xfer_size_pin_enable_r;
  logic proc_trace_pin_enable_r;
  logic bme_r;
  logic [2:0] bmt_r;
  logic [2:0] bmt_nxt;
  logic [16:0] wdog_cyc_r;
  logic [NWO-1:0] lock_r;
  logic [NWO-1:0] wo_lane;
  logic [NWO-1:0] wo_we;

  logic [15:0] ccr_word;
  logic [15:0] ccr_wdata;
  logic lane_hi;
  logic lane_lo;
  logic ccr_wr;
  logic access_ok;

  logic ack_r;
  logic terr_r;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;

  rcfg_capture #(
    .RESET_DEFAULT_CONFIG_DEFAULT(RESET_DEFAULT_CONFIG_DEFAULT)
  ) u_capture (
    .clock(CLOCK),
    .srst(SRST),
    .rcfg_n(RCFG_N),
    .ovr_pins(RCFG_DATA),
    .clkmod_pins(CLKMOD),
    .live_cfg(live_cfg),
    .held_cfg(held_cfg),
    .held_clkmod(CLOCK_MODE),
    .held_override(OVERRIDE_ACTIVE)
  );

  assign BOOT_CFG = held_cfg;

  // Address decode on the word offset; low address bits are ignored, byte enables select lanes
  always_comb begin
    if (BUS_REQ.addr[31:2] == 30'(`CC_OFS_CCR >> 2)) begin
      region = chip_config_pkg::REG_CCR;
    end else if (BUS_REQ.addr[31:2] == 30'(`CC_OFS_RESET_DEFAULT_CONFIG >> 2)) begin
      region = chip_config_pkg::REG_RESET_DEFAULT_CONFIG;
    end else if (BUS_REQ.addr[31:2] == 30'(`CC_OFS_RSVD >> 2)) begin
      region = chip_config_pkg::REG_RSVD;
    end else begin
      region = chip_config_pkg::REG_NONE;
    end
  end

  // Supervisor only; unmapped and user accesses change nothing
  assign access_ok = BUS_REQ.supervisor &&
                     (region != chip_config_pkg::REG_NONE);

  // The register sits in the upper half of its word
  assign ccr_wdata = BUS_REQ.wdata[31:16];
  assign lane_hi = BUS_REQ.be[3];
  assign lane_lo = BUS_REQ.be[2];
  assign ccr_wr = BUS_REQ.req && BUS_REQ.write && access_ok &&
                  (region == chip_config_pkg::REG_CCR);

  assign wo_lane[WO_LOAD] = lane_hi;
  assign wo_lane[WO_BME] = lane_lo;
  assign wo_lane[WO_BMT] = lane_lo;

  // A write in debug mode never arms the lock, so the field stays
  // writable once debug is left.
  genvar i;
  generate
    for (i = 0; i < NWO; i++) begin : g_once
      assign wo_we[i] = ccr_wr && wo_lane[i] &&
                        (!lock_r[i] || DEBUG_MODE);
      always_ff @(posedge CLOCK) begin
        if (SRST) begin
          lock_r[i] <= 1'b0;
        end else if (wo_we[i] && !DEBUG_MODE) begin
          lock_r[i] <= 1'b1;
        end
      end
    end
  endgenerate

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      load_r <= live_cfg.load;
    end else if (wo_we[WO_LOAD]) begin
      load_r <= ccr_wdata[`CC_BIT_LOAD];
    end
  end

  // Mode is fixed at reset and never written afterwards
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      mode_r <= live_cfg.master ? `CC_MODE_MASTER
                                : `CC_MODE_SINGLE;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      xfer_size_pin_enable_r <= live_cfg.master;
    end else if (ccr_wr && lane_lo) begin
      xfer_size_pin_enable_r <= ccr_wdata[`CC_BIT_XFER_SIZE_PIN_ENABLE];
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      proc_trace_pin_enable_r <= `CC_PROC_TRACE_PIN_ENABLE_RESET;
    end else if (ccr_wr && lane_lo) begin
      proc_trace_pin_enable_r <= ccr_wdata[`CC_BIT_PROC_TRACE_PIN_ENABLE];
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      bme_r <= `CC_BME_RESET;
    end else if (wo_we[WO_BME]) begin
      bme_r <= ccr_wdata[`CC_BIT_BME];
    end
  end

  always_comb begin
    if (SRST) begin
      bmt_nxt = `CC_BMT_RESET;
    end else if (wo_we[WO_BMT]) begin
      bmt_nxt = ccr_wdata[`CC_BIT_BMT_HI:`CC_BIT_BMT_LO];
    end else begin
      bmt_nxt = bmt_r;
    end
  end

  // Period is precomputed so the watchdog sees a flopped count
  always_ff @(posedge CLOCK) begin
    bmt_r <= bmt_nxt;
    wdog_cyc_r <= `CC_WDOG_BASE_CYC >> bmt_nxt;
  end

  // Reserved positions read as zero whatever was written
  always_comb begin
    ccr_word = 16'h0000;
    ccr_word[`CC_BIT_LOAD] = load_r;
    ccr_word[`CC_BIT_MODE_HI:`CC_BIT_MODE_LO] = mode_r;
    ccr_word[`CC_BIT_XFER_SIZE_PIN_ENABLE] = xfer_size_pin_enable_r;
    ccr_word[`CC_BIT_PROC_TRACE_PIN_ENABLE] = proc_trace_pin_enable_r;
    ccr_word[`CC_BIT_BME] = bme_r;
    ccr_word[`CC_BIT_BMT_HI:`CC_BIT_BMT_LO] = bmt_r;
  end

  // Lower halves belong to other modules and read as zero here
  always_comb begin
    unique case (region)
      chip_config_pkg::REG_CCR: rdata_nxt = {ccr_word, 16'h0000};
      chip_config_pkg::REG_RESET_DEFAULT_CONFIG: rdata_nxt = {RESET_DEFAULT_CONFIG_DEFAULT,
                                              16'h0000};
      chip_config_pkg::REG_RSVD: rdata_nxt = 32'h0000_0000;
      chip_config_pkg::REG_NONE: rdata_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      ack_r <= 1'b0;
      terr_r <= 1'b0;
    end else begin
      ack_r <= BUS_REQ.req && access_ok;
      terr_r <= BUS_REQ.req && !access_ok;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      rdata_r <= 32'h0000_0000;
    end else if (BUS_REQ.req) begin
      if (access_ok && !BUS_REQ.write) begin
        rdata_r <= rdata_nxt;
      end else begin
        rdata_r <= 32'h0000_0000;
      end
    end
  end

  assign BUS_RSP.ack = ack_r;
  assign BUS_RSP.terr = terr_r;
  assign BUS_RSP.rdata = rdata_r;

  // Continuous configuration to pad, pin mux and watchdog logic
  always_comb begin
    CCR_OUT.full_drive = load_r;
    CCR_OUT.chip_mode = mode_r;
    CCR_OUT.xfer_size_pin_enable = xfer_size_pin_enable_r;
    CCR_OUT.proc_trace_pin_enable = proc_trace_pin_enable_r;
    CCR_OUT.bus_watchdog_enable = bme_r;
    CCR_OUT.bus_watchdog_timeout = bmt_r;
    CCR_OUT.bus_watchdog_cycles = wdog_cyc_r;
  end

endmodule

// file: testbench/chip_config_monitor.sv
`timescale 1ns/10ps
module chip_config_monitor (
  input wire logic CLOCK,
  input wire logic SRST,
  input chip_config_pkg::bus_req_s BUS_REQ,
  input wire logic DEBUG_MODE,
  input wire logic RCFG_N,
  input wire logic [7:0] RCFG_DATA,
  input wire logic [1:0] CLKMOD,
  input chip_config_pkg::bus_rsp_s BUS_RSP,
  input chip_config_pkg::ccr_out_s CCR_OUT,
  input chip_config_pkg::rcfg_s BOOT_CFG,
  input wire logic [1:0] CLOCK_MODE,
  input wire logic OVERRIDE_ACTIVE
);
  default clocking @(posedge CLOCK);
  endclocking
  default disable iff (SRST);
  logic wr;
  logic lk_h_r;
  logic lk_l_r;
  assign wr = BUS_REQ.req && BUS_REQ.write && BUS_REQ.supervisor &&
              BUS_REQ.addr == 32'h0011_0004;
  // Lock shadow per lane, mirrors which write-once fields are closed
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      lk_h_r <= 1'b0;
      lk_l_r <= 1'b0;
    end else if (wr && !DEBUG_MODE) begin
      if (BUS_REQ.be[3])
        lk_h_r <= 1'b1;
      if (BUS_REQ.be[2])
        lk_l_r <= 1'b1;
    end
  end
  chk_user_terr: assert property (
    BUS_REQ.req && !BUS_REQ.supervisor |=> BUS_RSP.terr && !BUS_RSP.ack)
    else $error("user access not refused");
  chk_read_word: assert property (
    wr == 1'b0 && BUS_REQ.req && BUS_REQ.supervisor && !BUS_REQ.write &&
    BUS_REQ.addr == 32'h0011_0004 && !$past(BUS_REQ.req) |=> BUS_RSP.ack &&
    BUS_RSP.rdata == {CCR_OUT[26], 4'h0, CCR_OUT[25:23], 1'b0,
    CCR_OUT[22:21], 1'b0, CCR_OUT[20:17], 16'h0})
    else $error("read word differs from configuration");
  chk_mode_code: assert property (
    CCR_OUT.chip_mode[2:1] == 2'b11)
    else $error("mode field holds reserved code");
  chk_cfg_frozen: assert property (
    !$past(SRST) |-> $stable(BOOT_CFG) && $stable(OVERRIDE_ACTIVE) &&
    $stable(CCR_OUT.chip_mode))
    else $error("reset outcome changed outside reset");
  chk_reset_vals: assert property (
    $fell(SRST) |-> CCR_OUT.bus_watchdog_enable &&
    !CCR_OUT.proc_trace_pin_enable && CCR_OUT.bus_watchdog_timeout == 3'h0 &&
    CCR_OUT.xfer_size_pin_enable == CCR_OUT.chip_mode[0])
    else $error("configuration reset value wrong");
  chk_lock_hi: assert property (
    lk_h_r && wr && !DEBUG_MODE && BUS_REQ.be[3] |=>
    $stable(CCR_OUT.full_drive))
    else $error("locked drive bit changed");
  chk_lock_lo: assert property (
    lk_l_r && wr && !DEBUG_MODE && BUS_REQ.be[2] |=>
    $stable(CCR_OUT.bus_watchdog_enable) &&
    $stable(CCR_OUT.bus_watchdog_timeout))
    else $error("locked watchdog field changed");
  chk_debug_wr: assert property (
    wr && DEBUG_MODE && BUS_REQ.be[2] |=>
    CCR_OUT.bus_watchdog_timeout == $past(BUS_REQ.wdata[18:16]))
    else $error("debug write not applied");
  chk_plain_rw: assert property (
    wr && BUS_REQ.be[2] |=> {CCR_OUT.xfer_size_pin_enable,
    CCR_OUT.proc_trace_pin_enable} == $past(BUS_REQ.wdata[22:21]))
    else $error("pin enables not written");
  chk_cycles_map: assert property (
    CCR_OUT.bus_watchdog_cycles == 17'h10000 >> CCR_OUT.bus_watchdog_timeout)
    else $error("watchdog period does not match code");
endmodule

bind chip_config_register chip_config_monitor mon (.CLOCK(CLOCK),
  .SRST(SRST), .BUS_REQ(BUS_REQ), .DEBUG_MODE(DEBUG_MODE), .RCFG_N(RCFG_N),
  .RCFG_DATA(RCFG_DATA), .CLKMOD(CLKMOD), .BUS_RSP(BUS_RSP),
  .CCR_OUT(CCR_OUT), .BOOT_CFG(BOOT_CFG), .CLOCK_MODE(CLOCK_MODE),
  .OVERRIDE_ACTIVE(OVERRIDE_ACTIVE));

// file: testbench/chip_config_register_bench.sv
`timescale 1ns/10ps
`include "chip_config_cfg.svh"
module chip_config_register_bench;
  localparam logic [15:0] RD = `CC_RESET_DEFAULT_CONFIG_RESET;
  localparam logic [31:0] A_CCR = 32'h0011_0004;
  localparam logic [31:0] M = 32'h876f_0000;
  logic CLOCK, SRST, DEBUG_MODE, RCFG_N, OVERRIDE_ACTIVE;
  logic [7:0] RCFG_DATA;
  logic [1:0] CLKMOD, CLOCK_MODE;
  chip_config_pkg::bus_req_s BUS_REQ;
  chip_config_pkg::bus_rsp_s BUS_RSP;
  chip_config_pkg::ccr_out_s CCR_OUT;
  chip_config_pkg::rcfg_s BOOT_CFG;
  logic [33:0] exp_q[$];
  logic [31:0] seed = 32'h71292727;
  logic [31:0] r;
  int fails, cmp_count, cyc;
  logic dr, ms, xf, tr, bm, lh, ll;
  logic [2:0] bt;

  chip_config_register uut (.CLOCK(CLOCK), .SRST(SRST), .BUS_REQ(BUS_REQ),
    .DEBUG_MODE(DEBUG_MODE), .RCFG_N(RCFG_N), .RCFG_DATA(RCFG_DATA),
    .CLKMOD(CLKMOD), .BUS_RSP(BUS_RSP), .CCR_OUT(CCR_OUT),
    .BOOT_CFG(BOOT_CFG), .CLOCK_MODE(CLOCK_MODE),
    .OVERRIDE_ACTIVE(OVERRIDE_ACTIVE));

  always #2 CLOCK = ~CLOCK;

  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function logic [31:0] img();
    return {dr, 4'h0, 2'b11, ms, 1'b0, xf, tr, 1'b0, bm, bt, 16'h0};
  endfunction

  task check(input logic [33:0] seen, input logic [33:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task end_of_test;
    if (fails == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Back to back: each call launches at one edge and is taken at the next
  task acc(input logic w, input logic s, input logic [31:0] a,
           input logic [3:0] b, input logic [31:0] d, input logic [33:0] e);
    BUS_REQ <= {1'b1, w, s, a, b, d};
    exp_q.push_back(e);
    @(posedge CLOCK);
  endtask

  task idle;
    BUS_REQ.req <= 1'b0;
    @(posedge CLOCK);
  endtask

  task wr(input logic [31:0] d, input logic [3:0] b);
    if (b[3] && (DEBUG_MODE || !lh))
      dr = d[31];
    lh = lh | (b[3] & !DEBUG_MODE);
    if (b[2]) begin
      xf = d[22];
      tr = d[21];
      if (DEBUG_MODE || !ll) begin
        bm = d[19];
        bt = d[18:16];
      end
      ll = ll | !DEBUG_MODE;
    end
    acc(1'b1, 1'b1, A_CCR, b, d, 34'h2_0000_0000);
  endtask

  task look;
    acc(1'b0, 1'b1, A_CCR, 4'h0, 32'h0, {2'b10, img()});
    idle;
    check(CCR_OUT[26:17], {dr, 2'b11, ms, xf, tr, bm, bt});
    check(CCR_OUT.bus_watchdog_cycles, 17'h10000 >> bt);
  endtask

  task rst(input logic n, input logic [7:0] d, input logic [1:0] k);
    SRST <= 1'b1;
    BUS_REQ.req <= 1'b0;
    RCFG_N <= n;
    RCFG_DATA <= d;
    CLKMOD <= k;
    repeat (8) @(posedge CLOCK);
    SRST <= 1'b0;
    // Pins move after release so a leaky capture shows up
    RCFG_N <= !n;
    RCFG_DATA <= ~d;
    CLKMOD <= ~k;
    ms = n ? RD[0] : d[7];
    dr = n ? RD[5] : d[6];
    xf = ms;
    {tr, bm, bt, lh, ll} = 7'b0100000;
    @(posedge CLOCK);
    check(OVERRIDE_ACTIVE, !n);
    check(CLOCK_MODE, k);
    check(BOOT_CFG.master, ms);
    check(BOOT_CFG, n ? {RD[9:2], RD[0]} : {d[2:0], RD[6], d[6], d[4:3],
          d[5], d[7]});
    look;
  endtask

  always @(posedge CLOCK) begin
    cyc++;
    if (cyc == 2000) begin
      fails++;
      end_of_test;
    end
    if (!SRST && (BUS_RSP.ack | BUS_RSP.terr) === 1'b1)
      check({BUS_RSP.ack, BUS_RSP.terr, BUS_RSP.rdata},
            exp_q.size() > 0 ? exp_q.pop_front() : 34'h0);
  end

  initial begin
    {CLOCK, SRST, DEBUG_MODE, RCFG_N, RCFG_DATA, CLKMOD} = 14'h1400;
    BUS_REQ = '0;
    {fails, cmp_count, cyc} = '0;
    repeat (5) @(posedge CLOCK);
    rst(1'b1, 8'h00, 2'h1);
    acc(1'b1, 1'b0, A_CCR, 4'hc, M, 34'h1_0000_0000);
    acc(1'b0, 1'b1, 32'h0011_0010, 4'h0, 32'h0, 34'h1_0000_0000);
    acc(1'b0, 1'b1, 32'h0011_0008, 4'h0, 32'h0, {2'b10, RD, 16'h0});
    acc(1'b1, 1'b1, 32'h0011_0008, 4'hc, 32'hffff_0000, 34'h2_0000_0000);
    acc(1'b0, 1'b1, 32'h0011_0008, 4'h0, 32'h0, {2'b10, RD, 16'h0});
    acc(1'b1, 1'b1, 32'h0011_000c, 4'hf, 32'h0, 34'h2_0000_0000);
    acc(1'b0, 1'b1, 32'h0011_000c, 4'h0, 32'h0, 34'h2_0000_0000);
    look;
    for (int i = 0; i < 4; i++) begin
      wr(rnd() & M, 4'h4 << i[0]);
      wr(rnd() & M, 4'hc);
      look;
    end
    r = rnd();
    rst(1'b0, r[7:0] | 8'h80, r[9:8]);
    DEBUG_MODE <= 1'b1;
    idle;
    for (int c = 0; c < 8; c++) begin
      wr({c[0], 11'h0, 1'b1, c[2:0], 16'h0}, 4'hc);
      look;
    end
    DEBUG_MODE <= 1'b0;
    idle;
    wr(rnd() & M, 4'hc);
    wr(rnd() & M, 4'hc);
    look;
    rst(1'b0, r[7:0] & 8'h7f, r[1:0]);
    idle;
    check(exp_q.size(), 34'h0);
    end_of_test;
  end
endmodule
